// ===== logic/rls_pkg.sv
// constants, types and behaviour notes for the relay switch mode control
// Notes on behaviour
// - battery supply power-up restores register defaults and starts in standby
// - a one in leave_standby_cmd moves standby into the operating state
// - a one in enter_standby_cmd returns the operating state to standby
// - serial shifting and output line work from the logic supply alone
// - entering standby also clears the register banks to defaults
// - standby follows serial commands; losing the logic supply forces standby
// - any reset turns all channels off and loads register defaults
// - after any completed reset transfer_error_flag is set
// - during undervoltage reset every read returns the diagnostic frame with flag
// - undervoltage reset is released only when all supplies are good
// - soft_reset_cmd at one resets register bank and diagnosis at once
// - internal reset asserts within 1 us of a detected undervoltage
// - channel_source_select picks off, pin one, pin two or three, or on
// - an open direct input pin reads low, switching its channels off
// - a followed pin high acts as on, low acts as off

package rls_pkg;

	// -----------------------------------------------------------------
	// sizes and timing
	// -----------------------------------------------------------------
	localparam int             CH_N          = 8;
	localparam int             FRAME_W       = 24;
	localparam logic [4:0]     FRAME_BITS    = 5'(FRAME_W);
	localparam int             PIN_THREE_CH  = 4;
	localparam int             CLK_PERIOD_NS = 10;
	localparam int             UV_DELAY_NS   = 1000;
	localparam int             UV_DELAY_CYC  = UV_DELAY_NS / CLK_PERIOD_NS;

	// -----------------------------------------------------------------
	// bus register offsets and fields
	// -----------------------------------------------------------------
	localparam logic [4:0]     OFS_CTRL      = 5'h00;
	localparam logic [4:0]     OFS_SRC       = 5'h04;
	localparam logic [4:0]     OFS_STATUS    = 5'h08;
	localparam logic [4:0]     OFS_IRQ_STAT  = 5'h0c;
	localparam logic [4:0]     OFS_IRQ_MASK  = 5'h10;
	localparam int             CMD_WAKE      = 0;
	localparam int             ENTER_STANDBY_CMD       = 1;
	localparam int             CMD_RST       = 2;
	localparam int             ST_STB        = 0;
	localparam int             ST_TER        = 1;
	localparam int             ST_UV         = 2;
	localparam int             ST_OUT_LSB    = 8;
	localparam int             IRQ_RST       = 0;
	localparam int             IRQ_MODE      = 1;
	localparam int             IRQ_UV        = 2;
	localparam int             IRQ_FRM       = 3;
	localparam int             IRQ_W         = 4;

	// -----------------------------------------------------------------
	// serial frame layout
	// -----------------------------------------------------------------
	localparam int             FRM_WR        = 23;
	localparam logic [6:0]     SPI_ADDR_CMD  = 7'h00;
	localparam logic [6:0]     SPI_ADDR_SRC  = 7'h01;

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [15:0]    SRC_RST       = 16'h0000;
	localparam logic           TER_RST       = 1'b1;
	localparam logic [3:0]     MASK_RST      = 4'h0;
	localparam logic [2:0]     LINK_SYNC_RST = 3'h2;

	typedef enum logic [1:0] {
		SRC_OFF       = 2'h0,
		SRC_PIN_ONE   = 2'h1,
		SRC_PIN_TWO3  = 2'h2,
		SRC_ON        = 2'h3
	} rls_src_t;

	typedef enum logic {
		MODE_STANDBY,
		MODE_ACTIVE
	} rls_mode_t;

endpackage : rls_pkg

// ===== logic/rls_spi_link.sv
// oversampled serial shift link with daisy-chain pass-through
module rls_spi_link
	import rls_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               spiSclk,
	input  wire logic               spiCsN,
	input  wire logic               spiMosi,
	output      logic               spiMiso,
	output      logic               spiMisoOeN,
	input  wire logic [FRAME_W-1:0] replyWord,
	output      logic               frameValid,
	output      logic [FRAME_W-1:0] frameWord
);

	// -----------------------------------------------------------------
	// pin synchronisers: bit 0 clock, bit 1 select, bit 2 data
	// -----------------------------------------------------------------
	logic [2:0]         meta_r;
	logic [2:0]         sync_r;
	logic [2:0]         prev_r;
	logic [FRAME_W-1:0] sh_r;
	logic               bit_r;
	logic               lastRise_r;
	logic [4:0]         cnt_r;
	logic               sclkRise;
	logic               sclkFall;
	logic               csFall;
	logic               csRise;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= LINK_SYNC_RST;
			sync_r <= LINK_SYNC_RST;
			prev_r <= LINK_SYNC_RST;
		end else begin
			meta_r <= {spiMosi, spiCsN, spiSclk};
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign sclkRise = sync_r[0] & ~prev_r[0];
	assign sclkFall = ~sync_r[0] & prev_r[0];
	assign csFall   = ~sync_r[1] & prev_r[1];
	assign csRise   = sync_r[1] & ~prev_r[1];

	// -----------------------------------------------------------------
	// shifter: sample on rise, shift on fall; untouched by supply resets
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r       <= '0;
			bit_r      <= 1'b0;
			lastRise_r <= 1'b0;
			cnt_r      <= '0;
		end else if (csFall) begin
			sh_r       <= replyWord;
			cnt_r      <= '0;
			lastRise_r <= 1'b0;
		end else if (!sync_r[1]) begin
			if (sclkRise) begin
				bit_r      <= sync_r[2];
				lastRise_r <= 1'b1;
				if (cnt_r != FRAME_BITS)
					cnt_r <= cnt_r + 5'h01;
			end else if (sclkFall && lastRise_r) begin
				sh_r       <= {sh_r[FRAME_W-2:0], bit_r};
				lastRise_r <= 1'b0;
			end
		end
	end

	// last 24 bits at select release form the frame
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			frameValid <= 1'b0;
			frameWord  <= '0;
		end else begin
			frameValid <= csRise && (cnt_r == FRAME_BITS);
			if (csRise)
				frameWord <= lastRise_r ?
					{sh_r[FRAME_W-2:0], bit_r} : sh_r;
		end
	end

	assign spiMiso    = sh_r[FRAME_W-1];
	assign spiMisoOeN = sync_r[1];

endmodule : rls_spi_link

// ===== logic/rls_mode_ctrl.sv
// standby, reset and channel source control of the relay switch
module rls_mode_ctrl
	import rls_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic [4:0]      avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [31:0]     avs_writedata,
	input  wire logic [3:0]      avs_byteenable,
	output      logic [31:0]     avs_readdata,
	output      logic            avs_waitrequest,
	output      logic            irq,
	input  wire logic            spiSclk,
	input  wire logic            spiCsN,
	input  wire logic            spiMosi,
	output      logic            spiMiso,
	output      logic            spiMisoOeN,
	input  wire logic            vbbUvDet,
	input  wire logic            vddUvDet,
	input  wire logic            dinOne,
	input  wire logic            dinTwo,
	input  wire logic            dinThree,
	output      logic [CH_N-1:0] chanOut,
	output      logic            standbyState
);

	localparam int UvLim = UV_DELAY_CYC;

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	logic [4:0]         pinMeta_r;
	logic [4:0]         pinSync_r;
	logic [4:0]         pinRaw;
	logic               uvActive_r;
	logic               uvD_r;
	rls_mode_t          mode_r;
	rls_mode_t          modeD_r;
	logic [15:0]        srcSel_r;
	logic               ter_r;
	logic               regResetD_r;
	logic               readSrc_r;
	logic [IRQ_W-1:0]   irqStat_r;
	logic [IRQ_W-1:0]   irqMask_r;
	logic [IRQ_W-1:0]   irqEvt;
	logic               ack_r;
	logic [31:0]        readdata_r;
	logic [CH_N-1:0]    chanOut_r;
	logic [CH_N-1:0]    chanNxt;
	logic               frameValid;
	logic [FRAME_W-1:0] frameWord;
	logic [FRAME_W-1:0] replyWord;
	logic [FRAME_W-1:0] diagWord;
	logic               spiWr;
	logic               spiCmd;
	logic               spiSrc;
	logic               avsWrAcc;
	logic               avsCtrl;
	logic               wakeReq;
	logic               stbReq;
	logic               rstReq;
	logic               softRst;
	logic               regReset;
	logic               terSet;
	logic               terClr;
	logic               pinOne;
	logic               pinTwo;
	logic               pinThree;

	// -----------------------------------------------------------------
	// serial link
	// -----------------------------------------------------------------
	rls_spi_link u_link (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.spiSclk    (spiSclk),
		.spiCsN     (spiCsN),
		.spiMosi    (spiMosi),
		.spiMiso    (spiMiso),
		.spiMisoOeN (spiMisoOeN),
		.replyWord  (replyWord),
		.frameValid (frameValid),
		.frameWord  (frameWord)
	);

	// -----------------------------------------------------------------
	// pin synchronisers: 0 vbb uv, 1 vdd uv, 2..4 direct inputs
	// -----------------------------------------------------------------
	assign pinRaw = {dinThree, dinTwo, dinOne, vddUvDet, vbbUvDet};

	genvar gp;
	generate
		for (gp = 0; gp < 5; gp++) begin : g_pin
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					pinMeta_r[gp] <= 1'b0;
					pinSync_r[gp] <= 1'b0;
				end else begin
					pinMeta_r[gp] <= pinRaw[gp];
					pinSync_r[gp] <= pinMeta_r[gp];
				end
			end
		end
	endgenerate

	assign pinOne   = pinSync_r[2];
	assign pinTwo   = pinSync_r[3];
	assign pinThree = pinSync_r[4];

	// -----------------------------------------------------------------
	// undervoltage reset
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			uvActive_r <= 1'b0;
			uvD_r      <= 1'b0;
		end else begin
			uvActive_r <= pinSync_r[0] | pinSync_r[1];
			uvD_r      <= uvActive_r;
		end
	end

	// -----------------------------------------------------------------
	// command decode from link and bus
	// -----------------------------------------------------------------
	assign spiWr    = frameValid & frameWord[FRM_WR];
	assign spiCmd   = spiWr & (frameWord[22:16] == SPI_ADDR_CMD);
	assign spiSrc   = spiWr & (frameWord[22:16] == SPI_ADDR_SRC);
	assign avsWrAcc = avs_write & ack_r;
	assign avsCtrl  = avsWrAcc & (avs_address == OFS_CTRL) &
		avs_byteenable[0];
	assign wakeReq  = (spiCmd & frameWord[CMD_WAKE]) |
		(avsCtrl & avs_writedata[CMD_WAKE]);
	assign stbReq   = (spiCmd & frameWord[ENTER_STANDBY_CMD]) |
		(avsCtrl & avs_writedata[ENTER_STANDBY_CMD]);
	assign rstReq   = (spiCmd & frameWord[CMD_RST]) |
		(avsCtrl & avs_writedata[CMD_RST]);
	assign softRst  = rstReq & ~uvActive_r;
	assign regReset = uvActive_r | softRst | stbReq;

	// -----------------------------------------------------------------
	// operating state
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= MODE_STANDBY;
		end else begin
			case (mode_r)
				MODE_STANDBY: begin
					if (!uvActive_r && wakeReq && !stbReq)
						mode_r <= MODE_ACTIVE;
				end
				MODE_ACTIVE: begin
					if (uvActive_r || stbReq)
						mode_r <= MODE_STANDBY;
				end
				default: mode_r <= MODE_STANDBY;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			modeD_r <= MODE_STANDBY;
		else
			modeD_r <= mode_r;
	end

	assign standbyState = (mode_r == MODE_STANDBY);

	// -----------------------------------------------------------------
	// channel source selection register
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			srcSel_r <= SRC_RST;
		end else if (regReset) begin
			srcSel_r <= SRC_RST;
		end else if (spiSrc) begin
			srcSel_r <= frameWord[15:0];
		end else if (avsWrAcc && avs_address == OFS_SRC) begin
			if (avs_byteenable[0])
				srcSel_r[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				srcSel_r[15:8] <= avs_writedata[15:8];
		end
	end

	// -----------------------------------------------------------------
	// transfer error flag: set after any reset, cleared by a frame outside undervoltage
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			regResetD_r <= 1'b0;
		else
			regResetD_r <= regReset;
	end

	assign terSet = regResetD_r & ~regReset;
	assign terClr = frameValid & ~uvActive_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ter_r <= TER_RST;
		else if (terSet)
			ter_r <= 1'b1;
		else if (terClr)
			ter_r <= 1'b0;
	end

	// -----------------------------------------------------------------
	// reply frame
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			readSrc_r <= 1'b0;
		else if (frameValid)
			readSrc_r <= ~frameWord[FRM_WR] &
				(frameWord[22:16] == SPI_ADDR_SRC);
	end

	assign diagWord  = {ter_r | uvActive_r, standbyState, uvActive_r,
		5'h00, chanOut_r, 8'h00};
	assign replyWord = (readSrc_r && !uvActive_r) ?
		{diagWord[23:16], srcSel_r} : diagWord;

	// -----------------------------------------------------------------
	// per-channel drive source
	// -----------------------------------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < CH_N; gc++) begin : g_ch
			always_comb begin
				case (rls_src_t'(srcSel_r[2*gc +: 2]))
					SRC_OFF:      chanNxt[gc] = 1'b0;
					SRC_PIN_ONE:  chanNxt[gc] = pinOne;
					SRC_PIN_TWO3: chanNxt[gc] =
						(gc < PIN_THREE_CH) ? pinTwo : pinThree;
					SRC_ON:       chanNxt[gc] = 1'b1;
					default:      chanNxt[gc] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			chanOut_r <= '0;
		else if (regReset || mode_r != MODE_ACTIVE)
			chanOut_r <= '0;
		else
			chanOut_r <= chanNxt;
	end

	assign chanOut = chanOut_r;

	// -----------------------------------------------------------------
	// interrupt status and mask
	// -----------------------------------------------------------------
	assign irqEvt[IRQ_RST]  = terSet;
	assign irqEvt[IRQ_MODE] = (mode_r != modeD_r);
	assign irqEvt[IRQ_UV]   = uvActive_r & ~uvD_r;
	assign irqEvt[IRQ_FRM]  = frameValid;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			irqStat_r <= '0;
		else if (avs_read && ack_r && avs_address == OFS_IRQ_STAT)
			irqStat_r <= irqEvt;
		else
			irqStat_r <= irqStat_r | irqEvt;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			irqMask_r <= MASK_RST;
		else if (avsWrAcc && avs_address == OFS_IRQ_MASK &&
			avs_byteenable[0])
			irqMask_r <= avs_writedata[IRQ_W-1:0];
	end

	assign irq = |(irqStat_r & irqMask_r);

	// -----------------------------------------------------------------
	// bus slave: one wait state on every access
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_r <= '0;
		end else if (avs_read && !ack_r) begin
			readdata_r <= '0;
			if (avs_address == OFS_SRC)
				readdata_r[15:0] <= srcSel_r;
			else if (avs_address == OFS_STATUS) begin
				readdata_r[ST_STB] <= standbyState;
				readdata_r[ST_TER] <= ter_r | uvActive_r;
				readdata_r[ST_UV]  <= uvActive_r;
				readdata_r[ST_OUT_LSB +: CH_N] <= chanOut_r;
			end else if (avs_address == OFS_IRQ_STAT)
				readdata_r[IRQ_W-1:0] <= irqStat_r;
			else if (avs_address == OFS_IRQ_MASK)
				readdata_r[IRQ_W-1:0] <= irqMask_r;
		end
	end

	assign avs_readdata = readdata_r;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_UV_STANDBY: assert property (uvActive_r |=>
		mode_r == MODE_STANDBY && srcSel_r == SRC_RST)
		else $error("undervoltage did not force standby and defaults");
	AST_WAKE: assert property (mode_r == MODE_STANDBY && wakeReq &&
		!stbReq && !uvActive_r |=> mode_r == MODE_ACTIVE)
		else $error("wake command did not leave standby");
	AST_STB_PRIO: assert property (stbReq |=>
		mode_r == MODE_STANDBY ##1 chanOut == '0)
		else $error("standby request did not win");
	AST_STB_CLEAR: assert property (stbReq && mode_r == MODE_ACTIVE
		|=> srcSel_r == SRC_RST)
		else $error("standby entry kept register contents");
	AST_VDD_LOSS: assert property (vddUvDet [*5] |->
		mode_r == MODE_STANDBY)
		else $error("logic supply loss did not force standby");
	AST_RST_OFF: assert property (regReset |=>
		chanOut == '0 && srcSel_r == SRC_RST)
		else $error("reset left a channel on");
	AST_TER_SET: assert property ($fell(regReset) |->
		##1 ter_r)
		else $error("flag not set after reset");
	AST_UV_FRAME: assert property (uvActive_r |->
		replyWord == diagWord && replyWord[23])
		else $error("read during undervoltage not diagnostic");
	AST_UV_HOLD: assert property (pinSync_r[0] || pinSync_r[1] |=>
		uvActive_r)
		else $error("undervoltage reset released too early");
	AST_UV_DELAY: assert property ($rose(vbbUvDet) |->
		##[1:UvLim] (uvActive_r || !vbbUvDet))
		else $error("internal reset later than allowed");
	AST_SOFT_RST: assert property (softRst |=>
		srcSel_r == SRC_RST ##1 ter_r)
		else $error("soft reset did not clear registers");
	AST_SRC_ON: assert property (mode_r == MODE_ACTIVE &&
		!regReset && srcSel_r[1:0] == SRC_ON |=> chanOut[0])
		else $error("forced-on channel not driven");
	AST_PIN_FOLLOW: assert property (mode_r == MODE_ACTIVE &&
		!regReset && srcSel_r[1:0] == SRC_PIN_ONE |=>
		chanOut[0] == $past(pinOne))
		else $error("channel does not follow its pin");

	COV_WAKE: cover property (mode_r == MODE_STANDBY ##1
		mode_r == MODE_ACTIVE);
	COV_UV: cover property ($rose(uvActive_r) ##[1:1000] $fell(uvActive_r));
	COV_SOFT: cover property (softRst && mode_r == MODE_ACTIVE);
	COV_IRQ: cover property ($rose(irq));

endmodule : rls_mode_ctrl

// ===== sim/rls_spi_host.sv
// serial host model that sends frames to the relay switch link
module rls_spi_host (
	input  wire logic sys_clk,
	output      logic spiSclk,
	output      logic spiCsN,
	output      logic spiMosi,
	input  wire logic spiMiso,
	input  wire logic spiMisoOeN
);
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// frame transfer
	// ---------------------------------------------------------------
	// output enable seen at the first data sample of the latest frame
	logic oeSeen;

	initial begin
		oeSeen  = 1'b1;
		spiSclk = 1'b0;
		spiCsN  = 1'b1;
		spiMosi = 1'b0;
	end

	// 24 bits msb first, 80 ns clock period, clock still low between frames
	task automatic xfer(input logic [23:0] w, output logic [23:0] r);
		spiCsN <= 1'b0;
		repeat (8) @(posedge sys_clk);
		for (int i = 23; i >= 0; i--) begin
			spiMosi <= w[i];
			repeat (4) @(posedge sys_clk);
			spiSclk <= 1'b1;
			r[i] = spiMiso;
			if (i == 23)
				oeSeen = spiMisoOeN;
			repeat (4) @(posedge sys_clk);
			spiSclk <= 1'b0;
		end
		repeat (8) @(posedge sys_clk);
		spiCsN  <= 1'b1;
		// released data line shows the inverse of its last bit
		spiMosi <= ~w[0];
		repeat (8) @(posedge sys_clk);
	endtask : xfer
endmodule : rls_spi_host

// ===== sim/testbench.sv
// self-checking bench for the relay switch mode and source control
module testbench
	import rls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// signals and instances
	// ---------------------------------------------------------------
	typedef struct {
		logic [15:0] src;
		logic [2:0]  din;
		logic [7:0]  exp;
	} rls_row_t;

	logic            sys_clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [4:0]      avs_address = 5'h00;
	logic            avs_read = 1'b0;
	logic            avs_write = 1'b0;
	logic [31:0]     avs_writedata = 32'h0;
	logic [3:0]      avs_byteenable = 4'hf;
	logic [31:0]     avs_readdata, q;
	logic            avs_waitrequest, irq, spiMiso, spiMisoOeN;
	logic            spiSclk, spiCsN, spiMosi, standbyState;
	logic            vbbUvDet = 1'b0;
	logic            vddUvDet = 1'b0;
	logic            dinOne = 1'b0;
	logic            dinTwo = 1'b0;
	logic            dinThree = 1'b0;
	logic [CH_N-1:0] chanOut;
	logic [23:0]     r;
	int              miscompares = 0;
	int              checked = 0;
	int              cycles = 0;
	rls_row_t        rows [7] = '{
		'{16'hffff, 3'h0, 8'hff}, '{16'h5555, 3'h1, 8'hff},
		'{16'h5555, 3'h6, 8'h00}, '{16'haaaa, 3'h2, 8'h0f},
		'{16'haaaa, 3'h4, 8'hf0}, '{16'h0000, 3'h7, 8'h00},
		'{16'h1b1b, 3'h5, 8'h75}};

	rls_mode_ctrl DUT (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.irq, .spiSclk, .spiCsN, .spiMosi, .spiMiso, .spiMisoOeN, .vbbUvDet,
		.vddUvDet, .dinOne, .dinTwo, .dinThree, .chanOut, .standbyState);
	rls_spi_host host (.sys_clk, .spiSclk, .spiCsN, .spiMosi, .spiMiso,
		.spiMisoOeN);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [4:0] a,
			input logic [31:0] d, output logic [31:0] rd);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		@(posedge sys_clk);
		// one wait state on every access
		chk("waitrequest", 32'h1, 32'(avs_waitrequest));
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic rdchk(input string nm, input logic [4:0] a,
			input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(nm, e, v);
	endtask : rdchk

	task automatic pins(input logic [7:0] ch, input logic sb);
		@(negedge sys_clk);
		chk("chanOut", 32'(ch), 32'(chanOut));
		chk("standby", 32'(sb), 32'(standbyState));
		@(posedge sys_clk);
	endtask : pins

	task automatic wait_chan(input logic [7:0] e, input int lim);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (chanOut !== e && n < lim) begin
			@(negedge sys_clk);
			n++;
		end
		chk("chanOut", 32'(e), 32'(chanOut));
		@(posedge sys_clk);
	endtask : wait_chan

	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		pins(8'h00, 1'b1);
		rdchk("status", OFS_STATUS, 32'h3);
		rdchk("unmapped", 5'h14, 32'h0);
		rdchk("mask", OFS_IRQ_MASK, 32'h0);
		host.xfer({1'b1, SPI_ADDR_CMD, 16'h0001}, r);
		chk("reply", 32'h6, 32'(r[23:21]));
		chk("misoOen", 32'h0, 32'(host.oeSeen));
		pins(8'h00, 1'b0);
		foreach (rows[i]) begin
			{dinThree, dinTwo, dinOne} <= rows[i].din;
			bus(1'b1, OFS_SRC, 32'(rows[i].src), q);
			wait_chan(rows[i].exp, 20);
			rdchk("src", OFS_SRC, 32'(rows[i].src));
		end
		bus(1'b1, OFS_IRQ_MASK, 32'h2, q);
		@(negedge sys_clk);
		chk("irq", 32'h1, 32'(irq));
		@(posedge sys_clk);
		bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
		chk("irqstat", 32'h1, 32'(q[IRQ_MODE]));
		@(negedge sys_clk);
		chk("irq", 32'h0, 32'(irq));
		@(posedge sys_clk);
		bus(1'b1, OFS_SRC, 32'hffff, q);
		wait_chan(8'hff, 20);
		host.xfer({1'b1, SPI_ADDR_CMD, 16'h0004}, r);
		chk("reply", 32'h0, 32'(r[23:21]));
		pins(8'h00, 1'b0);
		rdchk("status", OFS_STATUS, 32'h2);
		rdchk("src", OFS_SRC, 32'h0);
		bus(1'b1, OFS_SRC, 32'hffff, q);
		wait_chan(8'hff, 20);
		host.xfer({1'b1, SPI_ADDR_CMD, 16'h0003}, r);
		pins(8'h00, 1'b1);
		rdchk("src", OFS_SRC, 32'h0);
		rdchk("status", OFS_STATUS, 32'h3);
		host.xfer({1'b1, SPI_ADDR_CMD, 16'h0001}, r);
		bus(1'b1, OFS_SRC, 32'hffff, q);
		wait_chan(8'hff, 20);
		vbbUvDet <= 1'b1;
		vddUvDet <= 1'b1;
		wait_chan(8'h00, UV_DELAY_CYC);
		host.xfer({1'b0, SPI_ADDR_SRC, 16'h0000}, r);
		chk("uvreply", 32'h3, 32'({r[23], r[21]}));
		vbbUvDet <= 1'b0;
		repeat (UV_DELAY_CYC) @(posedge sys_clk);
		rdchk("status", OFS_STATUS, 32'h7);
		vddUvDet <= 1'b0;
		repeat (UV_DELAY_CYC) @(posedge sys_clk);
		rdchk("status", OFS_STATUS, 32'h3);
		give_verdict();
	end
endmodule : testbench
